// ===== design/rcmdg_pkg.sv
// Constants, types and helpers for the region clock mux, divide and gate block
package rcmdg_pkg;

  localparam int unsigned RCMDG_NUM_GLOBAL = 48;
  localparam int unsigned RCMDG_NUM_DIRECT = 12;
  localparam int unsigned RCMDG_NUM_DATA = 4;
  localparam int unsigned RCMDG_NUM_HALF = 2;
  localparam int unsigned RCMDG_HALF_CAND = 32;
  localparam int unsigned RCMDG_HALF_OUT = 8;
  localparam int unsigned RCMDG_BUS_W = 16;
  localparam int unsigned RCMDG_LANES_PER_CLUSTER = 13;
  localparam int unsigned RCMDG_FWD_REGIONS = 3;
  localparam int unsigned RCMDG_GLB_PER_HALF = RCMDG_NUM_GLOBAL / RCMDG_NUM_HALF;
  localparam int unsigned RCMDG_DIR_PER_HALF = RCMDG_NUM_DIRECT / RCMDG_NUM_HALF;
  localparam int unsigned RCMDG_DAT_PER_HALF = RCMDG_NUM_DATA / RCMDG_NUM_HALF;

  // Register byte addresses
  localparam logic [11:0] RCMDG_REG_LANE = 12'h000;
  localparam logic [11:0] RCMDG_REG_JUNC = 12'h004;
  localparam logic [11:0] RCMDG_REG_STAT = 12'h008;
  localparam logic [11:0] RCMDG_REG_CFG0 = 12'h040;
  localparam logic [11:0] RCMDG_REG_CFG_LAST = 12'h07c;

  // Channel configuration fields
  localparam int unsigned RCMDG_CFG_SRC_A_LSB = 0;
  localparam int unsigned RCMDG_CFG_SRC_B_LSB = 8;
  localparam int unsigned RCMDG_CFG_DIV_LSB = 16;
  localparam int unsigned RCMDG_CFG_MODE_BIT = 20;
  localparam logic [31:0] RCMDG_CFG_MASK = 32'h001f1f1f;
  localparam logic [31:0] RCMDG_CFG_RESET = 32'h00000000;

  // Lane and junction fields
  localparam int unsigned RCMDG_LANE_RATE_LSB = 16;
  localparam logic [31:0] RCMDG_LANE_MASK = 32'h0003ffff;
  localparam logic [31:0] RCMDG_LANE_RESET = 32'h00000000;
  localparam int unsigned RCMDG_JUNC_CL_IDX_LSB = 0;
  localparam int unsigned RCMDG_JUNC_CL_DATA_BIT = 4;
  localparam int unsigned RCMDG_JUNC_DAT_IDX_LSB = 5;
  localparam int unsigned RCMDG_JUNC_CTL_IDX_LSB = 8;
  localparam logic [31:0] RCMDG_JUNC_MASK = 32'h00000f7f;
  localparam logic [31:0] RCMDG_JUNC_RESET = 32'h00000000;

  localparam logic [1:0] RCMDG_LANE_FULL = 2'h0;
  localparam logic [1:0] RCMDG_LANE_HALF = 2'h1;
  localparam logic [1:0] RCMDG_LANE_QUARTER = 2'h2;

  typedef logic [2:0] rcmdg_div_t;
  localparam rcmdg_div_t RCMDG_DIV_BY1 = 3'h0;
  localparam rcmdg_div_t RCMDG_DIV_BY2 = 3'h1;
  localparam rcmdg_div_t RCMDG_DIV_BY4 = 3'h2;
  localparam rcmdg_div_t RCMDG_DIV_BY6 = 3'h3;
  localparam rcmdg_div_t RCMDG_DIV_BY8 = 3'h4;

  typedef enum logic [2:0] {
    RCMDG_SW_RUN = 3'b001,
    RCMDG_SW_DROP = 3'b010,
    RCMDG_SW_ARM = 3'b100
  } rcmdg_sw_state_t;

  // Source edges per output half period; zero means bypass
  function automatic logic [2:0] rcmdg_half_count(input rcmdg_div_t code);
    logic [2:0] h;
    h = 3'h0;
    if (code == RCMDG_DIV_BY2) h = 3'h1;
    else if (code == RCMDG_DIV_BY4) h = 3'h2;
    else if (code == RCMDG_DIV_BY6) h = 3'h3;
    else if (code == RCMDG_DIV_BY8) h = 3'h4;
    return h;
  endfunction

endpackage

// ===== design/rcmdg_chan.sv
// One output channel: two dividers feeding an enable gate or a glitchless switch
`timescale 1ns/1ps
`default_nettype none
module rcmdg_chan (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Candidate clocks chosen by the selection half
  input wire logic src_a,
  input wire logic src_b,
  // Static configuration
  input wire rcmdg_pkg::rcmdg_div_t div_code,
  input wire logic sw_mode,
  // Fabric controls
  input wire logic gate_en,
  input wire logic sw_sel,
  // Results
  output logic clk_out_q,
  output logic sel_now_q
);
  import rcmdg_pkg::*;

  logic [1:0] prev_q;
  logic [1:0] tgl_q;
  logic [2:0] cnt_q [2];
  logic en_q;
  rcmdg_sw_state_t st_q;
  rcmdg_sw_state_t st_d;

  wire [1:0] src = {src_b, src_a};
  wire [1:0] rise = src & ~prev_q;
  wire [2:0] half = rcmdg_half_count(div_code);
  wire bypass = (half == 3'h0);
  wire [1:0] dclk = bypass ? src : tgl_q;
  wire cur_clk = dclk[sel_now_q];
  wire new_clk = dclk[~sel_now_q];
  wire gated = dclk[0] & en_q;
  wire sw_pass = (st_q == RCMDG_SW_RUN) || (st_q == RCMDG_SW_DROP);
  wire out_d = sw_mode ? (sw_pass & cur_clk) : gated;

  // Both dividers share the static ratio
  always_ff @(posedge ref_clk) begin
    for (int k = 0; k < 2; k++) begin
      if (!rst_n || bypass) begin
        cnt_q[k] <= 3'h0;
        tgl_q[k] <= 1'b0;
      end else if (rise[k]) begin
        if (cnt_q[k] == half - 3'h1) begin
          cnt_q[k] <= 3'h0;
          tgl_q[k] <= ~tgl_q[k];
        end else begin
          cnt_q[k] <= cnt_q[k] + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev_q <= 2'h0;
    end else begin
      prev_q <= src;
    end
  end

  // Enable only moves while the divided clock is low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en_q <= 1'b0;
    end else if (!dclk[0]) begin
      en_q <= gate_en;
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      RCMDG_SW_RUN: begin
        if (sw_mode && (sw_sel != sel_now_q)) st_d = RCMDG_SW_DROP;
      end
      RCMDG_SW_DROP: begin
        if (!cur_clk) st_d = RCMDG_SW_ARM;
      end
      RCMDG_SW_ARM: begin
        if (!new_clk) st_d = RCMDG_SW_RUN;
      end
      default: st_d = RCMDG_SW_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= RCMDG_SW_RUN;
      sel_now_q <= 1'b0;
      clk_out_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == RCMDG_SW_ARM && !new_clk) sel_now_q <= ~sel_now_q;
      clk_out_q <= out_d;
    end
  end

  sw_drop_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_q == RCMDG_SW_DROP ##1 st_q == RCMDG_SW_ARM) |-> !clk_out_q)
    else $error("switch dropped old clock while high");

  sw_arm_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_q == RCMDG_SW_ARM) [*2] |-> !clk_out_q)
    else $error("switch output active while arming");

  gate_no_cut_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(en_q) |-> !$past(dclk[0]))
    else $error("gate enable changed while clock high");

  sw_sel_track_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sw_mode && st_q == RCMDG_SW_RUN && sw_sel != sel_now_q) |=> (st_q == RCMDG_SW_DROP))
    else $error("switch ignored new select");

  div_cnt_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !bypass |-> (cnt_q[0] < half) && (cnt_q[1] < half))
    else $error("divider count beyond ratio");

endmodule // rcmdg_chan
`default_nettype wire

// ===== design/rcmdg_top.sv
// Region clock manager: selection halves, per-clock channels, lane clocks, AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module rcmdg_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Clock sources from the hub and the fabric
  input wire logic [rcmdg_pkg::RCMDG_NUM_GLOBAL-1:0] glob_clk,
  input wire logic [rcmdg_pkg::RCMDG_NUM_DIRECT-1:0] dir_clk,
  input wire logic [rcmdg_pkg::RCMDG_NUM_DATA-1:0] data_clk,
  // Fabric run-time controls
  input wire logic [rcmdg_pkg::RCMDG_BUS_W-1:0] fab_gate_en,
  input wire logic [rcmdg_pkg::RCMDG_BUS_W-1:0] fab_sw_sel,
  // Byte-lane strobe clock of the IO cluster
  input wire logic lane_strobe,
  // Clock outputs
  output logic [rcmdg_pkg::RCMDG_BUS_W-1:0] region_bus_q,
  output logic [rcmdg_pkg::RCMDG_BUS_W-1:0] col_clk_q,
  output logic [rcmdg_pkg::RCMDG_FWD_REGIONS-1:0] lane_fwd_q,
  output logic cluster_clk_q,
  output logic bus_ctl_q
);
  import rcmdg_pkg::*;

  logic [31:0] cfg_q [RCMDG_BUS_W];
  logic [31:0] lane_cfg_q;
  logic [31:0] junc_cfg_q;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic lane_prev_q;
  logic lane_div2_q;
  logic lane_div4_q;
  logic [RCMDG_BUS_W-1:0] chan_clk;
  logic [RCMDG_BUS_W-1:0] chan_sel;
  logic [RCMDG_HALF_CAND-1:0] cand [RCMDG_NUM_HALF];

  // Each half sees half the hub clocks and a pair of fabric data clocks
  for (genvar h = 0; h < RCMDG_NUM_HALF; h++) begin : g_half
    assign cand[h] = {data_clk[h*RCMDG_DAT_PER_HALF +: RCMDG_DAT_PER_HALF],
                      dir_clk[h*RCMDG_DIR_PER_HALF +: RCMDG_DIR_PER_HALF],
                      glob_clk[h*RCMDG_GLB_PER_HALF +: RCMDG_GLB_PER_HALF]};
  end

  for (genvar i = 0; i < RCMDG_BUS_W; i++) begin : g_ch
    wire [4:0] sel_a = cfg_q[i][RCMDG_CFG_SRC_A_LSB +: 5];
    wire [4:0] sel_b = cfg_q[i][RCMDG_CFG_SRC_B_LSB +: 5];
    wire pick_a = cand[i / RCMDG_HALF_OUT][sel_a];
    wire pick_b = cand[i / RCMDG_HALF_OUT][sel_b];
    rcmdg_chan u_chan (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .src_a(pick_a),
      .src_b(pick_b),
      .div_code(cfg_q[i][RCMDG_CFG_DIV_LSB +: 3]),
      .sw_mode(cfg_q[i][RCMDG_CFG_MODE_BIT]),
      .gate_en(fab_gate_en[i]),
      .sw_sel(fab_sw_sel[i]),
      .clk_out_q(chan_clk[i]),
      .sel_now_q(chan_sel[i])
    );
  end

  // Byte-lane strobe dividers
  wire lane_rise = lane_strobe & ~lane_prev_q;
  wire [1:0] lane_rate = lane_cfg_q[RCMDG_LANE_RATE_LSB +: 2];
  wire lane_pick = (lane_rate == RCMDG_LANE_HALF) ? lane_div2_q :
                   (lane_rate == RCMDG_LANE_QUARTER) ? lane_div4_q : lane_strobe;
  wire [RCMDG_BUS_W-1:0] lane_mask = lane_cfg_q[RCMDG_BUS_W-1:0];
  wire [RCMDG_BUS_W-1:0] col_d = (chan_clk & ~lane_mask) | ({RCMDG_BUS_W{lane_pick}} & lane_mask);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lane_prev_q <= 1'b0;
      lane_div2_q <= 1'b0;
      lane_div4_q <= 1'b0;
    end else begin
      lane_prev_q <= lane_strobe;
      if (lane_rise) lane_div2_q <= ~lane_div2_q;
      if (lane_rise && lane_div2_q) lane_div4_q <= ~lane_div4_q;
    end
  end

  // Junctions between the clock bus and the fabric
  wire [3:0] cl_idx = junc_cfg_q[RCMDG_JUNC_CL_IDX_LSB +: 4];
  wire cl_use_data = junc_cfg_q[RCMDG_JUNC_CL_DATA_BIT];
  wire [1:0] dat_idx = junc_cfg_q[RCMDG_JUNC_DAT_IDX_LSB +: 2];
  wire [3:0] ctl_idx = junc_cfg_q[RCMDG_JUNC_CTL_IDX_LSB +: 4];
  wire cluster_d = cl_use_data ? data_clk[dat_idx] : chan_clk[cl_idx];
  wire ctl_d = chan_clk[ctl_idx];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      region_bus_q <= '0;
      col_clk_q <= '0;
      lane_fwd_q <= '0;
      cluster_clk_q <= 1'b0;
      bus_ctl_q <= 1'b0;
    end else begin
      region_bus_q <= chan_clk;
      col_clk_q <= col_d;
      lane_fwd_q <= {RCMDG_FWD_REGIONS{lane_pick}};
      cluster_clk_q <= cluster_d;
      bus_ctl_q <= ctl_d;
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  wire addr_phase = hsel && htrans[1] && hready;
  wire rd_take = addr_phase && !hwrite;
  wire wr_take = addr_phase && hwrite;
  wire rd_is_cfg = (haddr >= RCMDG_REG_CFG0) && (haddr <= RCMDG_REG_CFG_LAST);
  wire [3:0] rd_cfg_idx = haddr[5:2];
  wire wr_is_cfg = (wr_addr_q >= RCMDG_REG_CFG0) && (wr_addr_q <= RCMDG_REG_CFG_LAST);
  wire [3:0] wr_cfg_idx = wr_addr_q[5:2];
  wire [31:0] stat_word = {16'h0000, chan_sel};
  wire [31:0] rd_word = (haddr == RCMDG_REG_LANE) ? lane_cfg_q :
                        (haddr == RCMDG_REG_JUNC) ? junc_cfg_q :
                        (haddr == RCMDG_REG_STAT) ? stat_word :
                        rd_is_cfg ? cfg_q[rd_cfg_idx] : 32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
    end else begin
      wr_pend_q <= wr_take;
      if (wr_take) wr_addr_q <= {haddr[11:2], 2'h0};
      if (rd_take) hrdata_q <= rd_word;
      hreadyout_q <= 1'b1;
    end
  end

  // Software config is static in intent; fabric never writes it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lane_cfg_q <= RCMDG_LANE_RESET;
      junc_cfg_q <= RCMDG_JUNC_RESET;
      for (int i = 0; i < RCMDG_BUS_W; i++) cfg_q[i] <= RCMDG_CFG_RESET;
    end else if (wr_pend_q) begin
      if (wr_addr_q == RCMDG_REG_LANE) lane_cfg_q <= hwdata & RCMDG_LANE_MASK;
      else if (wr_addr_q == RCMDG_REG_JUNC) junc_cfg_q <= hwdata & RCMDG_JUNC_MASK;
      else if (wr_is_cfg) cfg_q[wr_cfg_idx] <= hwdata & RCMDG_CFG_MASK;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;

  stat_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rd_take && haddr == RCMDG_REG_STAT) |=> (hrdata[RCMDG_BUS_W-1:0] == $past(chan_sel)))
    else $error("status read does not show switch selects");

  lane_div2_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(lane_div2_q) |-> $past(lane_rise))
    else $error("half-rate lane clock moved without strobe edge");

  lane_div4_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(lane_div4_q) |-> $past(lane_rise && lane_div2_q))
    else $error("quarter-rate lane clock moved off cadence");

  col_mux_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lane_mask == '0) ##1 (lane_mask == '0) |-> (col_clk_q == region_bus_q))
    else $error("column clocks differ from bus with no lane override");

  data_junc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cl_use_data |=> (cluster_clk_q == $past(data_clk[dat_idx])))
    else $error("cluster clock not taken from data signal");

endmodule // rcmdg_top
`default_nettype wire

// ===== verif/rcmdg_fabric_model.sv
// Fabric logic and byte-lane model driving sources and run-time controls
`timescale 1ns/1ps
`default_nettype none
module rcmdg_fabric_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic [rcmdg_pkg::RCMDG_BUS_W-1:0] gate_req,
  input wire logic [rcmdg_pkg::RCMDG_BUS_W-1:0] sel_req,
  // Toward the block
  output logic [rcmdg_pkg::RCMDG_NUM_GLOBAL-1:0] glob_clk,
  output logic [rcmdg_pkg::RCMDG_NUM_DIRECT-1:0] dir_clk,
  output logic [rcmdg_pkg::RCMDG_NUM_DATA-1:0] data_clk,
  output logic lane_strobe,
  output logic [rcmdg_pkg::RCMDG_BUS_W-1:0] fab_gate_en,
  output logic [rcmdg_pkg::RCMDG_BUS_W-1:0] fab_sw_sel
);
  import rcmdg_pkg::*;
  logic [3:0] cnt_q;
  always_ff @(posedge ref_clk) begin
    cnt_q <= rst_n ? cnt_q + 4'h1 : 4'h0;
  end
  // Periods of 4, 8 or 16 cycles so adjacent candidates differ in rate
  always_comb begin
    for (int i = 0; i < 48; i++) glob_clk[i] = cnt_q[1 + i % 3];
    for (int j = 0; j < 12; j++) dir_clk[j] = cnt_q[1 + (j + 1) % 3];
    for (int k = 0; k < 4; k++) data_clk[k] = cnt_q[1 + (k + 2) % 3];
    lane_strobe = cnt_q[1];
  end
  // Only enables and selects come from the fabric, never ratios
  always_ff @(posedge ref_clk) begin
    fab_gate_en <= gate_req;
    fab_sw_sel <= sel_req;
  end
endmodule // rcmdg_fabric_model
`default_nettype wire

// ===== verif/rcmdg_top_bench.sv
// Self-checking bench for the region clock mux, divide and gate block
`timescale 1ns/1ps
`default_nettype none
module rcmdg_top_bench;
  import rcmdg_pkg::*;
  logic ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, cluster_clk_q, bus_ctl_q, lane_strobe;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, lane_fwd_q;
  logic [31:0] hwdata, hrdata, q;
  logic [47:0] glob_clk;
  logic [11:0] dir_clk;
  logic [3:0] data_clk;
  logic [15:0] gate_req, sel_req, fab_gate_en, fab_sw_sel, region_bus_q, col_clk_q;
  wire logic hready;
  int bad_count, total_checks, cyc, n, minrun, maxrun, eqbad;
  logic [11:0] addrs [6];
  logic [31:0] masks [6];
  // Channel, candidate, ratio code, rises per 480-cycle window
  int rows [10][4] = '{'{0, 0, 0, 120}, '{1, 1, 1, 30}, '{2, 2, 2, 7}, '{3, 0, 3, 20}, '{4, 0, 4, 15},
    '{7, 24, 1, 30}, '{9, 26, 0, 120}, '{12, 31, 0, 30}, '{15, 23, 1, 15}, '{8, 30, 0, 60}};
  assign hready = hreadyout;
  rcmdg_top i_rcmdg_top (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .glob_clk(glob_clk), .dir_clk(dir_clk), .data_clk(data_clk), .fab_gate_en(fab_gate_en),
    .fab_sw_sel(fab_sw_sel), .lane_strobe(lane_strobe), .region_bus_q(region_bus_q), .col_clk_q(col_clk_q),
    .lane_fwd_q(lane_fwd_q), .cluster_clk_q(cluster_clk_q), .bus_ctl_q(bus_ctl_q));
  rcmdg_fabric_model i_rcmdg_fabric_model (.ref_clk(ref_clk), .rst_n(rst_n), .gate_req(gate_req),
    .sel_req(sel_req), .glob_clk(glob_clk), .dir_clk(dir_clk), .data_clk(data_clk), .lane_strobe(lane_strobe),
    .fab_gate_en(fab_gate_en), .fab_sw_sel(fab_sw_sel));
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Tolerance absorbs a window edge landing mid-period
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int tol);
    total_checks++;
    if ((g !== e) && (tol == 0 || $isunknown(g) || g > e + tol || g + tol < e)) begin
      bad_count++;
      $display("unexpected %s: expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic ahb(input logic [11:0] a, input logic wr, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  function automatic logic pick(input int s);
    if (s < 16) return region_bus_q[s];
    if (s < 32) return col_clk_q[s - 16];
    if (s == 32) return lane_fwd_q[0];
    if (s == 33) return cluster_clk_q;
    return bus_ctl_q;
  endfunction
  // Counts rises and tracks whole high-pulse lengths; a partial first pulse is ignored
  task automatic measure(input int s, output int rises);
    logic prev;
    logic v;
    int run;
    rises = 0;
    minrun = 99;
    maxrun = 0;
    eqbad = 0;
    run = -1000;
    prev = 1'b1;
    repeat (480) begin
      @(posedge ref_clk);
      v = pick(s);
      if (v === 1'b1 && prev === 1'b0) rises++;
      if (v === 1'b1) run++;
      else begin
        if (run > 0) minrun = (run < minrun) ? run : minrun;
        if (run > 0) maxrun = (run > maxrun) ? run : maxrun;
        run = 0;
      end
      if (!(lane_fwd_q inside {3'h0, 3'h7})) eqbad++;
      prev = v;
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge ref_clk);
      cyc++;
      if (cyc == 40000) begin
        bad_count++;
        results;
      end
    end
  end
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 12'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    gate_req = 16'hffff;
    sel_req = 16'h0;
    addrs = '{RCMDG_REG_LANE, RCMDG_REG_JUNC, RCMDG_REG_STAT, RCMDG_REG_CFG0, RCMDG_REG_CFG_LAST, 12'h100};
    masks = '{RCMDG_LANE_MASK, RCMDG_JUNC_MASK, 32'h0, RCMDG_CFG_MASK, RCMDG_CFG_MASK, 32'h0};
    repeat (8) @(posedge ref_clk);
    chk("bus in reset", 32'h0, 32'(region_bus_q), 0);
    chk("ready in reset", 32'h1, 32'(hreadyout), 0);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 6; i++) begin
      ahb(addrs[i], 1'b0, 32'h0, q);
      chk("reset value", 32'h0, q, 0);
      ahb(addrs[i], 1'b1, 32'hffffffff, q);
      ahb(addrs[i], 1'b0, 32'h0, q);
      chk("written value", masks[i], q, 0);
      ahb(addrs[i], 1'b1, 32'h0, q);
    end
    chk("response", 32'h0, 32'(hresp), 0);
    for (int i = 0; i < 10; i++)
      ahb(RCMDG_REG_CFG0 + 12'(4 * rows[i][0]), 1'b1, 32'(rows[i][1]) | (32'(rows[i][2]) << 16), q);
    repeat (64) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      measure(rows[i][0], n);
      chk("channel rises", rows[i][3], n, 1);
      measure(16 + rows[i][0], n);
      chk("column rises", rows[i][3], n, 1);
    end
    gate_req[0] <= 1'b0;
    repeat (16) @(posedge ref_clk);
    measure(0, n);
    chk("gated rises", 32'h0, n, 0);
    fork
      measure(0, n);
      repeat (150) begin
        repeat (3) @(posedge ref_clk);
        gate_req[0] <= ~gate_req[0];
      end
    join
    chk("gate pulse", 32'h1, 32'(minrun == 2 && maxrun == 2 && n > 0), 0);
    // Switch mode must ignore the dropped enable
    gate_req[5] <= 1'b0;
    ahb(RCMDG_REG_CFG0 + 12'h014, 1'b1, 32'h00110200, q);
    for (int s = 0; s < 2; s++) begin
      sel_req[5] <= s[0];
      repeat (64) @(posedge ref_clk);
      measure(5, n);
      chk("switch rises", s ? 15 : 60, n, 1);
      ahb(RCMDG_REG_STAT, 1'b0, 32'h0, q);
      chk("switch state", s ? 32'h20 : 32'h0, q, 0);
    end
    fork
      measure(5, n);
      repeat (68) begin
        repeat (7) @(posedge ref_clk);
        sel_req[5] <= ~sel_req[5];
      end
    join
    chk("switch pulse", 32'h1, 32'(minrun >= 4 && maxrun <= 16), 0);
    for (int r = 0; r < 3; r++) begin
      ahb(RCMDG_REG_LANE, 1'b1, (32'(r) << RCMDG_LANE_RATE_LSB) | 32'h1, q);
      repeat (64) @(posedge ref_clk);
      measure(32, n);
      chk("lane rises", 120 >> r, n, 1);
      chk("lane copies", 32'h0, eqbad, 0);
      measure(16, n);
      chk("masked column rises", 120 >> r, n, 1);
    end
    ahb(RCMDG_REG_JUNC, 1'b1, 32'h00000130, q);
    repeat (64) @(posedge ref_clk);
    measure(33, n);
    chk("cluster rises", 120, n, 1);
    measure(34, n);
    chk("control rises", 30, n, 1);
    ahb(RCMDG_REG_JUNC, 1'b1, 32'h00000302, q);
    repeat (64) @(posedge ref_clk);
    measure(33, n);
    chk("cluster rises", 7, n, 1);
    measure(34, n);
    chk("control rises", 20, n, 1);
    // Mid-run reset must drop every clock output and forget the switch and config state
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("bus in mid reset", 32'h0, 32'(region_bus_q), 0);
    chk("columns in mid reset", 32'h0, 32'(col_clk_q), 0);
    chk("lane in mid reset", 32'h0, 32'(lane_fwd_q), 0);
    chk("junctions in mid reset", 32'h0, 32'({cluster_clk_q, bus_ctl_q}), 0);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    ahb(RCMDG_REG_CFG0 + 12'h004, 1'b0, 32'h0, q);
    chk("config after mid reset", 32'h0, q, 0);
    ahb(RCMDG_REG_LANE, 1'b0, 32'h0, q);
    chk("lane after mid reset", 32'h0, q, 0);
    ahb(RCMDG_REG_STAT, 1'b0, 32'h0, q);
    chk("switch state after mid reset", 32'h0, q, 0);
    results;
  end
endmodule // rcmdg_top_bench
`default_nettype wire
